// file: design/i2cs_fifo.sv
// Write-commit FIFO between the serial engine and the register file
`timescale 1ns/1ps
module i2cs_fifo
    import i2cs_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clock, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic in_valid, // Push request
    output logic in_ready, // Room for one more word
    input wire logic [WIDTH-1:0] in_data, // Pushed word
    output logic out_valid, // Word available
    input wire logic out_ready, // Consumer takes the word
    output logic [WIDTH-1:0] out_data // Oldest word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0] cnt_q;
    logic push, pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule : i2cs_fifo

// file: design/i2cs_port.sv
// Slave-only two-wire register port: framing, addressing, acknowledge, write commit
//
// Functional notes
// - Each byte is nine clocks: eight data bits MSB first, then acknowledge.
// - SDA changes while SCL high are control conditions, never data.
// - Idle bus rests with both lines released high.
// - START is SDA falling with SCL high; STOP is SDA rising with SCL high.
// - Repeated start behaves as a START and begins a new address phase.
// - After STOP or unmatched address, ignore SCL until the next START.
// - Acknowledge drives SDA low before ninth rising edge, through its high phase.
// - Not-acknowledge leaves SDA released through the ninth clock.
// - Every 8-bit pointer value is acknowledged, implemented or not.
// - Main address 0x48 matches, seen as 0x90 write and 0x91 read.
// - Addresses 0x25 and 0x50 are acknowledged but do nothing else.
// - SCL is never held low; it is an input only.
// - General call address byte 0x00 gets no acknowledge.
// - Works to 3.4MHz in high-speed mode, 1MHz otherwise, from 0Hz.
// - Power-up and every STOP select the 1MHz-or-slower filters.
// - Repeated start keeps filter mode; STOP returns to slow filters.
// - Write order: address W, pointer, data, each answered, then STOP or Sr.
// - Written byte commits on the SDA rising edge after its acknowledge slot; here also at the next data byte's acknowledge fall.
// - Further data bytes are acknowledged and written to successive registers; here a byte that meets a full write FIFO is not-acknowledged and not written.
// - Master code 0000_1xxx after START is not-acknowledged and enables high speed.
// - Read: pointer write, repeated start, address R, slave sends, master acks.
// - STOP leaves the register pointer unchanged.
`timescale 1ns/1ps
module i2cs_port
    import i2cs_pkg::*;
#(
    parameter int FIFO_WORDS = FIFO_DEPTH
) (
    input wire logic clock, // 100 MHz system clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic scl_i, // Bus clock pin level
    input wire logic sda_i, // Bus data pin level
    output logic sda_o, // Data pin drive value, always low
    output logic sda_oe, // High while pulling SDA low
    output logic hs_mode, // High-speed input filters selected
    output logic [7:0] rd_addr, // Register selected for reading
    output logic rd_strobe, // One-cycle pulse when rd_data is taken
    input wire logic [7:0] rd_data, // Register contents at rd_addr
    output logic wr_valid, // Committed write waiting
    input wire logic wr_ready, // Register file takes the write
    output logic [7:0] wr_addr, // Register written
    output logic [7:0] wr_data, // Value written
    output logic busy // Byte engine active, from any START until STOP or return to idle
);
    logic [1:0] pin_s1_q, pin_s2_q;
    // One bit per pin, each driven by its own filter instance below
    wire [1:0] filt_q;
    logic scl_f_q, sda_f_q;
    logic scl_rise, scl_fall, start_det, stop_det, sda_rise;
    i2cs_state_e state_q;
    i2cs_byte_e kind_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic read_q, aux_q, more_q;
    logic sda_oe_q, hs_q, strobe_q;
    logic pend_q;
    logic [7:0] pend_addr_q, pend_data_q;
    logic push, fifo_ready;
    logic [15:0] fifo_out;
    logic addr_hit, addr_aux, hs_code;
    logic [6:0] rx_addr;

    // Two-flop synchronisers; only the second stage is looked at
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_s1_q <= 2'h3;
            pin_s2_q <= 2'h3;
        end else begin
            pin_s1_q <= {scl_i, sda_i};
            pin_s2_q <= pin_s1_q;
        end
    end

    // Spike filters; span depends on the selected speed range
    for (genvar g = 0; g < 2; g++) begin : g_filt
        logic [3:0] cnt_q;
        logic [3:0] lim;
        logic lvl_q;
        assign lim = hs_q ? 4'(FILT_HS_CYC) : 4'(FILT_FS_CYC);
        assign filt_q[g] = lvl_q;
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                cnt_q <= 4'h0;
                lvl_q <= 1'b1;
            end else if (pin_s2_q[g] == filt_q[g]) begin
                cnt_q <= 4'h0;
            end else if (cnt_q + 4'h1 >= lim) begin
                cnt_q <= 4'h0;
                lvl_q <= pin_s2_q[g];
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
        end else begin
            scl_f_q <= filt_q[1];
            sda_f_q <= filt_q[0];
        end
    end

    assign scl_rise = filt_q[1] && !scl_f_q;
    assign scl_fall = !filt_q[1] && scl_f_q;
    // SDA moving while SCL stays high is a bus condition, not data
    assign start_det = scl_f_q && filt_q[1] && sda_f_q && !filt_q[0];
    assign stop_det = scl_f_q && filt_q[1] && !sda_f_q && filt_q[0];
    assign sda_rise = filt_q[0] && !sda_f_q;

    assign rx_addr = shift_q[7:1];
    assign addr_hit = (rx_addr == ADDR_MAIN);
    assign addr_aux = (rx_addr == ADDR_AUX0) || (rx_addr == ADDR_AUX1);
    assign hs_code = (shift_q[7:3] == HS_CODE_TOP);

    // Byte engine
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= I2CS_IDLE;
            kind_q <= I2CS_B_ADDR;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            read_q <= 1'b0;
            aux_q <= 1'b0;
            more_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (start_det) begin
            // A repeated start simply restarts the address phase
            state_q <= I2CS_RX;
            kind_q <= I2CS_B_ADDR;
            bit_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end else if (stop_det) begin
            state_q <= I2CS_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (state_q)
                I2CS_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                I2CS_RX: begin
                    if (scl_rise && bit_q != 4'(BYTE_BITS)) begin
                        shift_q <= {shift_q[6:0], filt_q[0]};
                        bit_q <= bit_q + 4'h1;
                    end else if (scl_fall && bit_q == 4'(BYTE_BITS)) begin
                        // Decide the answer on the eighth fall, ahead of the ninth rise
                        state_q <= I2CS_ACK;
                        case (kind_q)
                            I2CS_B_ADDR: begin
                                read_q <= shift_q[0];
                                aux_q <= addr_aux;
                                if (shift_q == GEN_CALL) begin
                                    sda_oe_q <= 1'b0;
                                    state_q <= I2CS_IDLE;
                                end else if (hs_code) begin
                                    sda_oe_q <= 1'b0;
                                    state_q <= I2CS_IDLE;
                                end else if (addr_hit || addr_aux) begin
                                    sda_oe_q <= 1'b1;
                                end else begin
                                    sda_oe_q <= 1'b0;
                                    state_q <= I2CS_IDLE;
                                end
                            end
                            I2CS_B_PTR: begin
                                sda_oe_q <= 1'b1;
                            end
                            I2CS_B_DATA: begin
                                // Clock stretching is not allowed, so a full FIFO refuses
                                sda_oe_q <= fifo_ready;
                            end
                            default: begin
                                sda_oe_q <= 1'b0;
                            end
                        endcase
                    end
                end
                I2CS_ACK: begin
                    if (scl_fall) begin
                        bit_q <= 4'h0;
                        if (kind_q == I2CS_B_ADDR && aux_q) begin
                            sda_oe_q <= 1'b0;
                            state_q <= I2CS_IDLE;
                        end else if (kind_q == I2CS_B_ADDR && read_q) begin
                            shift_q <= {rd_data[6:0], 1'b0};
                            sda_oe_q <= !rd_data[7];
                            state_q <= I2CS_TX;
                        end else begin
                            sda_oe_q <= 1'b0;
                            kind_q <= (kind_q == I2CS_B_ADDR) ? I2CS_B_PTR : I2CS_B_DATA;
                            state_q <= I2CS_RX;
                        end
                    end
                end
                I2CS_TX: begin
                    if (scl_fall) begin
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'(BYTE_BITS - 1)) begin
                            sda_oe_q <= 1'b0;
                            state_q <= I2CS_RACK;
                        end else begin
                            sda_oe_q <= !shift_q[7];
                            shift_q <= {shift_q[6:0], 1'b0};
                        end
                    end
                end
                I2CS_RACK: begin
                    if (scl_rise) begin
                        more_q <= !filt_q[0];
                    end else if (scl_fall) begin
                        bit_q <= 4'h0;
                        if (more_q) begin
                            shift_q <= {rd_data[6:0], 1'b0};
                            sda_oe_q <= !rd_data[7];
                            state_q <= I2CS_TX;
                        end else begin
                            state_q <= I2CS_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= I2CS_IDLE;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // Filter mode: master code enables high speed, only reset or STOP restores slow
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hs_q <= 1'b0;
        end else if (stop_det) begin
            hs_q <= 1'b0;
        end else if (state_q == I2CS_RX && kind_q == I2CS_B_ADDR && scl_fall
                     && bit_q == 4'(BYTE_BITS) && hs_code) begin
            hs_q <= 1'b1;
        end
    end

    // Register pointer; never touched by STOP
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ptr_q <= PTR_RESET;
        end else if (state_q == I2CS_ACK && scl_fall && kind_q == I2CS_B_PTR) begin
            ptr_q <= shift_q;
        end else if (state_q == I2CS_ACK && scl_fall && kind_q == I2CS_B_DATA
                     && sda_oe_q) begin
            ptr_q <= ptr_q + 8'h01;
        end else if (state_q == I2CS_TX && scl_fall && bit_q == 4'(BYTE_BITS - 1)) begin
            ptr_q <= ptr_q + 8'h01;
        end
    end

    // Read strobe marks each byte taken from rd_data
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= scl_fall && !start_det && !stop_det &&
                        ((state_q == I2CS_ACK && kind_q == I2CS_B_ADDR && read_q && !aux_q)
                         || (state_q == I2CS_RACK && more_q));
        end
    end

    // Accepted byte waits for the next SDA rise, or the next data byte's acknowledge fall, before it takes effect
    assign push = pend_q && (sda_rise || (state_q == I2CS_ACK && kind_q == I2CS_B_DATA
                  && sda_oe_q && scl_fall));

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
            pend_addr_q <= 8'h00;
            pend_data_q <= 8'h00;
        end else if (state_q == I2CS_ACK && kind_q == I2CS_B_DATA && sda_oe_q
                     && scl_fall && !start_det && !stop_det) begin
            pend_q <= 1'b1;
            pend_addr_q <= ptr_q;
            pend_data_q <= shift_q;
        end else if (push) begin
            pend_q <= 1'b0;
        end
    end

    i2cs_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_WORDS)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data({pend_addr_q, pend_data_q}),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(fifo_out)
    );

    assign wr_addr = fifo_out[15:8];
    assign wr_data = fifo_out[7:0];
    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_q;
    assign hs_mode = hs_q;
    assign rd_addr = ptr_q;
    assign rd_strobe = strobe_q;
    assign busy = (state_q != I2CS_IDLE);
endmodule : i2cs_port

// file: dv/i2cs_master_model.sv
// Behavioural bus master that drives the clock and data lines of the port
`timescale 1ns/1ps
module i2cs_master_model (
    input wire logic clock, // Paces the bus timing
    input wire logic sda_i, // Wired data line level
    output logic scl_o, // Bus clock, rests high between frames
    output logic sda_oe // High while pulling data low
);
    initial begin
        scl_o = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic wait_cyc(input int n);
        repeat (n) begin
            @(posedge clock);
            #1;
        end
    endtask : wait_cyc
    // Low 10 cycles, high 6: 160 ns a bit; low kept long since the port answers late
    task automatic put_bit(input logic b, output logic s);
        wait_cyc(4);
        sda_oe = !b;
        wait_cyc(6);
        scl_o = 1'b1;
        wait_cyc(5);
        s = sda_i;
        wait_cyc(1);
        scl_o = 1'b0;
    endtask : put_bit
    // Start (also repeated) when stop is 0, stop condition when 1
    task automatic frame(input logic stop);
        wait_cyc(4);
        sda_oe = stop;
        wait_cyc(6);
        scl_o = 1'b1;
        wait_cyc(6);
        sda_oe = !stop;
        wait_cyc(6);
        scl_o = stop;
        if (stop) wait_cyc(16);
    endtask : frame
    // Nine clocks a byte, MSB first; the ninth carries ack_in from the master
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                        output logic ack_out);
        logic s;
        for (int i = 0; i < 8; i++) begin
            put_bit(tx[7 - i], s);
            rx[7 - i] = s;
        end
        put_bit(ack_in, ack_out);
    endtask : xfer
endmodule : i2cs_master_model

// file: dv/i2cs_port_sva.sv
// Concurrent checks on the pins of the two-wire register slave port
`timescale 1ns/1ps
module i2cs_port_sva (
    input wire logic clock, // System clock
    input wire logic rst_n, // Reset, active low
    input wire logic scl_i, // Bus clock pin
    input wire logic sda_i, // Bus data pin
    input wire logic sda_o, // Data drive value
    input wire logic sda_oe, // Data pull enable
    input wire logic hs_mode, // Fast filters
    input wire logic [7:0] rd_addr, // Pointer
    input wire logic rd_strobe, // Read take pulse
    input wire logic wr_valid, // Write waiting
    input wire logic wr_ready, // Write taken
    input wire logic [7:0] wr_addr, // Write target
    input wire logic [7:0] wr_data, // Write value
    input wire logic busy // Transfer active
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    AST_RST_QUIET: assert property (disable iff (1'b0) !rst_n |=> !sda_oe && !hs_mode
        && !busy && !wr_valid && !rd_strobe && rd_addr == 8'h00) else $error("reset left state");
    AST_IDLE_FREE: assert property (!busy && $past(!busy) |-> !sda_oe)
        else $error("data pulled while idle");
    AST_HS_STOP: assert property (scl_i && $rose(sda_i) |-> ##[1:20] !hs_mode)
        else $error("fast filters kept after stop");
    AST_HS_SR: assert property (scl_i && $fell(sda_i) && hs_mode |=> hs_mode [*8])
        else $error("fast filters lost at start");
    AST_PTR_STOP: assert property (scl_i && $rose(sda_i) |=> $stable(rd_addr) [*8])
        else $error("pointer moved at stop");
    AST_STROBE_PULSE: assert property (rd_strobe |=> !rd_strobe)
        else $error("read strobe longer than one cycle");
    AST_STROBE_BUSY: assert property (rd_strobe |-> busy)
        else $error("read strobe outside transfer");
    AST_OD_LOW: assert property (sda_oe |-> !sda_o)
        else $error("data driven high");
    AST_WR_HOLD: assert property (wr_valid && !wr_ready |=>
        wr_valid && $stable(wr_addr) && $stable(wr_data)) else $error("stalled write changed");
    cover property ($rose(hs_mode));
    cover property (wr_valid && wr_ready);
    cover property (rd_strobe);
endmodule : i2cs_port_sva

bind i2cs_port i2cs_port_sva u_sva (.clock(clock), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .hs_mode(hs_mode), .rd_addr(rd_addr), .rd_strobe(rd_strobe),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy));

// file: dv/i2cs_port_test.sv
// Self-checking bench for the two-wire register slave port
`timescale 1ns/1ps
module i2cs_port_test
    import i2cs_pkg::*;
;
    localparam int FIFO_W = 2; // Small buffer so a stalled consumer fills it fast
    logic clock;
    logic rst_n;
    logic wr_ready;
    logic [7:0] regs [256];
    logic [7:0] rd_addr, rd_data, wr_addr, wr_data;
    logic sda_o, sda_oe, hs_mode, rd_strobe, wr_valid, busy, scl, m_sda_oe, sda;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    assign sda = !(sda_oe || m_sda_oe); // Pull-up wins unless someone pulls low
    assign rd_data = regs[rd_addr];
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        wr_ready = 1'b0;
        for (int i = 0; i < 256; i++) regs[i] = 8'h00;
        forever #5 clock = ~clock;
    end
    i2cs_port #(.FIFO_WORDS(FIFO_W)) dut (.clock(clock), .rst_n(rst_n), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .hs_mode(hs_mode), .rd_addr(rd_addr),
        .rd_strobe(rd_strobe), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy));
    i2cs_master_model mst (.clock(clock), .sda_i(sda), .scl_o(scl), .sda_oe(m_sda_oe));
    always @(posedge clock) begin
        if (wr_valid && wr_ready) regs[wr_addr] <= wr_data;
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic put(input logic [7:0] b, input logic nack, input string what);
        logic [7:0] rx;
        logic a;
        mst.xfer(b, 1'b1, rx, a);
        check(what, a, nack);
    endtask : put
    task automatic t_access();
        logic [7:0] rx;
        logic a;
        wr_ready = 1'b1;
        mst.frame(1'b0);
        put({ADDR_MAIN, 1'b0}, 1'b0, "write address");
        put(8'hfe, 1'b0, "pointer");
        put(8'h81, 1'b0, "first data");
        put(8'hc3, 1'b0, "second data");
        mst.frame(1'b1);
        check("first register", regs[8'hfe], 8'h81);
        check("next register", regs[8'hff], 8'hc3);
        check("pointer after stop", rd_addr, 8'h00);
        mst.frame(1'b0);
        put({ADDR_MAIN, 1'b0}, 1'b0, "write address");
        put(8'hfe, 1'b0, "pointer");
        mst.frame(1'b0);
        put({ADDR_MAIN, 1'b1}, 1'b0, "read address");
        mst.xfer(8'hff, 1'b0, rx, a);
        check("first read byte", rx, 8'h81);
        mst.xfer(8'hff, 1'b1, rx, a);
        check("second read byte", rx, 8'hc3);
        mst.frame(1'b1);
        check("pointer kept", rd_addr, 8'h00);
        $display("test access done");
    endtask : t_access
    task automatic t_refuse();
        logic [7:0] addrs [4] = '{GEN_CALL, 8'h92, {ADDR_AUX0, 1'b0}, {ADDR_AUX1, 1'b0}};
        // Consumer stalled so any stray write would stay visible
        wr_ready = 1'b0;
        for (int i = 0; i < 4; i++) begin
            mst.frame(1'b0);
            put(addrs[i], i < 2, "address answer");
            put(8'h10, 1'b1, "ignored byte");
            mst.frame(1'b1);
        end
        check("no write queued", wr_valid, 1'b0);
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_fast();
        mst.frame(1'b0);
        put(8'h0d, 1'b1, "master code");
        mst.wait_cyc(12);
        check("fast filters on", hs_mode, 1'b1);
        mst.frame(1'b0);
        put({ADDR_MAIN, 1'b0}, 1'b0, "fast address");
        check("fast filters kept", hs_mode, 1'b1);
        mst.frame(1'b1);
        check("slow filters after stop", hs_mode, 1'b0);
        $display("test fast done");
    endtask : t_fast
    task automatic t_fifo();
        wr_ready = 1'b0;
        mst.frame(1'b0);
        put({ADDR_MAIN, 1'b0}, 1'b0, "write address");
        put(8'h10, 1'b0, "pointer");
        for (int i = 0; i < 3; i++) begin
            put(8'h81 + i[7:0], i >= FIFO_W, "data with stalled consumer");
        end
        mst.frame(1'b1);
        check("oldest target held", wr_addr, 8'h10);
        check("oldest value held", wr_data, 8'h81);
        wr_ready = 1'b1;
        mst.wait_cyc(4);
        check("buffer drained", wr_valid, 1'b0);
        check("second write", regs[8'h11], 8'h82);
        // The refused byte is sent again once the buffer has room
        mst.frame(1'b0);
        put({ADDR_MAIN, 1'b0}, 1'b0, "retry address");
        put(8'h12, 1'b0, "retry pointer");
        put(8'h83, 1'b0, "retried data");
        mst.frame(1'b1);
        check("retried write", regs[8'h12], 8'h83);
        $display("test fifo done");
    endtask : t_fifo
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        mst.wait_cyc(5);
        rst_n = 1'b1;
        mst.wait_cyc(20);
        t_access();
        t_refuse();
        t_fast();
        t_fifo();
        report_and_stop();
    end
endmodule : i2cs_port_test

// file: shared/i2cs_pkg.sv
// Constants and types shared by the two-wire register slave port
package i2cs_pkg;
    localparam int CLK_MHZ = 100;
    // Spike widths rejected by the input filters, in ns
    localparam int FILT_FS_NS = 50;
    localparam int FILT_HS_NS = 10;
    localparam int FILT_FS_CYC = (FILT_FS_NS * CLK_MHZ / 1000) < 1 ? 1 :
                                 (FILT_FS_NS * CLK_MHZ / 1000);
    localparam int FILT_HS_CYC = (FILT_HS_NS * CLK_MHZ / 1000) < 1 ? 1 :
                                 (FILT_HS_NS * CLK_MHZ / 1000);
    localparam logic [6:0] ADDR_MAIN = 7'h48;
    localparam logic [6:0] ADDR_AUX0 = 7'h25;
    localparam logic [6:0] ADDR_AUX1 = 7'h50;
    localparam logic [7:0] GEN_CALL = 8'h00;
    localparam logic [4:0] HS_CODE_TOP = 5'h01;
    localparam int BYTE_BITS = 8;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [2:0] {
        I2CS_IDLE = 3'b000,
        I2CS_RX = 3'b001,
        I2CS_ACK = 3'b011,
        I2CS_TX = 3'b010,
        I2CS_RACK = 3'b110
    } i2cs_state_e;

    typedef enum logic [1:0] {
        I2CS_B_ADDR = 2'h0,
        I2CS_B_PTR = 2'h1,
        I2CS_B_DATA = 2'h2
    } i2cs_byte_e;
endpackage : i2cs_pkg
